/* File: verilog/phf_pkg.sv */
// Constants for the port H function and pad control block.
// Assumes a 32-bit AXI4-Lite register bus and a 7-pin port.
package phf_pkg;
    localparam int PIN_COUNT = 7;
    localparam logic [7:0] OFS_ALT_TWO   = 8'h0c;
    localparam logic [7:0] OFS_ALT_THREE = 8'h10;
    localparam logic [7:0] OFS_ALT_FOUR  = 8'h14;
    localparam logic [7:0] OFS_DRIVER    = 8'h28;
    localparam logic [7:0] OFS_PULLUP    = 8'h2c;
    localparam logic [7:0] OFS_PLAIN_OUT = 8'h00;
    localparam logic [7:0] OFS_PLAIN_OE  = 8'h04;
    localparam logic [31:0] MASK_ALT_TWO   = 32'h0000001f;
    localparam logic [31:0] MASK_ALT_THREE = 32'h00000018;
    localparam logic [31:0] MASK_ALT_FOUR  = 32'h00000004;
    localparam logic [31:0] MASK_PIN       = 32'h0000007f;
    localparam logic [31:0] RESET_VALUE    = 32'h00000000;
    localparam int BIT_TX    = 0;
    localparam int BIT_RX    = 1;
    localparam int BIT_CLK   = 2;
    localparam int BIT_CNT0  = 3;
    localparam int BIT_CNT1  = 4;
    localparam int BIT_TMR4  = 3;
    localparam int BIT_TMR5  = 4;
    localparam int BIT_CTS   = 2;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/phf_pad_mux.sv */
// Per-pin output selection and driver shaping.
// Assumes the selects are mutually exclusive as software keeps them.
`timescale 1ns/10ps
module phf_pad_mux
    import phf_pkg::*;
(
    // Pin configuration
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic [PIN_COUNT-1:0] func_en_i,
    input  wire logic [PIN_COUNT-1:0] func_val_i,
    input  wire logic [PIN_COUNT-1:0] func_oe_i,
    input  wire logic [PIN_COUNT-1:0] plain_val_i,
    input  wire logic [PIN_COUNT-1:0] plain_oe_i,
    input  wire logic [PIN_COUNT-1:0] open_drain_i,
    // Pad drive
    output logic      [PIN_COUNT-1:0] pad_out_o,
    output logic      [PIN_COUNT-1:0] pad_oe_o
);
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : gen_pin
            logic val;
            logic oe;
            assign val = func_en_i[g] ? func_val_i[g] : plain_val_i[g];
            assign oe  = func_en_i[g] ? func_oe_i[g] : plain_oe_i[g];
            always_ff @(posedge clk_sys_i) begin
                if (rst_i) begin
                    pad_out_o[g] <= 1'b0;
                    pad_oe_o[g]  <= 1'b0;
                end else if (open_drain_i[g]) begin
                    pad_out_o[g] <= 1'b0;
                    pad_oe_o[g]  <= oe & ~val;
                end else begin
                    pad_out_o[g] <= val;
                    pad_oe_o[g]  <= oe;
                end
            end
        end
    endgenerate
endmodule

/* File: verilog/phf_port_h.sv */
// Port H alternate-function selection, driver type and pull-up control.
// Assumes an AXI4-Lite master that keeps one write and one read in flight.
// Overview of operation
// - Second select bit 0 routes pin 0 to serial channel 4 transmit.
// - Second select bit 1 routes pin 1 to serial channel 4 receive.
// - Second select bit 2 routes pin 2 to serial channel 4 clock.
// - Second select bits 3 and 4 route pins 3 and 4 to pulse counter 3 inputs.
// - Second select bits 31 to 5 read zero.
// - Third select bits 3 and 4 drive pins 3 and 4 from timers 4 and 5.
// - Third select bits other than 3 and 4 read zero.
// - Fourth select bit 2 routes pin 2 to serial channel 4 clear-to-send.
// - Fourth select bits other than 2 read zero.
// - Driver type bits choose push-pull or open-drain per pin; upper bits read zero.
// - Pull-up bits switch each pin pull-up on or off.
// - Pull-up bits 31 to 7 read zero.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module phf_port_h
    import phf_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    // AXI4-Lite write address and data
    input  wire logic [7:0]           s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    output logic [31:0]               s_axi_rdata_o,
    output logic [1:0]                s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i,
    // Pads
    input  wire logic [PIN_COUNT-1:0] pad_in_i,
    output logic      [PIN_COUNT-1:0] pad_out_o,
    output logic      [PIN_COUNT-1:0] pad_oe_o,
    output logic      [PIN_COUNT-1:0] pad_pullup_o,
    // Peripheral side
    input  wire logic                 serial4_transmit_line_i,
    output logic                      serial4_receive_line_o,
    input  wire logic                 serial4_clock_out_i,
    input  wire logic                 serial4_clock_oe_i,
    output logic                      serial4_clock_line_o,
    output logic                      serial4_clear_to_send_line_o,
    output logic                      pulse_counter3_input0_o,
    output logic                      pulse_counter3_input1_o,
    input  wire logic                 timer4_output_i,
    input  wire logic                 timer5_output_i,
    output logic [PIN_COUNT-1:0]      port_in_o
);
    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [31:0]          alt_two_reg;
    logic [31:0]          alt_three_reg;
    logic [31:0]          alt_four_reg;
    logic [31:0]          driver_reg;
    logic [31:0]          pullup_reg;
    logic [31:0]          plain_out_reg;
    logic [31:0]          plain_oe_reg;
    logic [7:0]           aw_addr_reg;
    logic                 aw_held_reg;
    logic [31:0]          w_data_reg;
    logic [3:0]           w_strb_reg;
    logic                 w_held_reg;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return (a == OFS_ALT_TWO) || (a == OFS_ALT_THREE) || (a == OFS_ALT_FOUR) ||
               (a == OFS_DRIVER) || (a == OFS_PULLUP) || (a == OFS_PLAIN_OUT) || (a == OFS_PLAIN_OE);
    endfunction

    logic do_write;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;

    // ****************************************************************
    // Write channel
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_held_reg     <= 1'b0;
            aw_addr_reg     <= 8'h00;
            s_axi_awready_o <= 1'b0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg     <= 1'b1;
            aw_addr_reg     <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (do_write) begin
            aw_held_reg     <= 1'b0;
        end else begin
            s_axi_awready_o <= !aw_held_reg && !s_axi_awready_o;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            w_held_reg     <= 1'b0;
            w_data_reg     <= 32'h00000000;
            w_strb_reg     <= 4'h0;
            s_axi_wready_o <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg     <= 1'b1;
            w_data_reg     <= s_axi_wdata_i;
            w_strb_reg     <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (do_write) begin
            w_held_reg     <= 1'b0;
        end else begin
            s_axi_wready_o <= !w_held_reg && !s_axi_wready_o;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // All writable bits clear at reset; masks keep read-only bits at zero.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            alt_two_reg   <= RESET_VALUE;
            alt_three_reg <= RESET_VALUE;
            alt_four_reg  <= RESET_VALUE;
            driver_reg    <= RESET_VALUE;
            pullup_reg    <= RESET_VALUE;
            plain_out_reg <= RESET_VALUE;
            plain_oe_reg  <= RESET_VALUE;
        end else if (do_write) begin
            unique case (aw_addr_reg)
                OFS_ALT_TWO: begin
                    alt_two_reg <= merge(alt_two_reg, w_data_reg, w_strb_reg, MASK_ALT_TWO);
                end
                OFS_ALT_THREE: begin
                    alt_three_reg <= merge(alt_three_reg, w_data_reg, w_strb_reg, MASK_ALT_THREE);
                end
                OFS_ALT_FOUR: begin
                    alt_four_reg <= merge(alt_four_reg, w_data_reg, w_strb_reg, MASK_ALT_FOUR);
                end
                OFS_DRIVER: begin
                    driver_reg <= merge(driver_reg, w_data_reg, w_strb_reg, MASK_PIN);
                end
                OFS_PULLUP: begin
                    pullup_reg <= merge(pullup_reg, w_data_reg, w_strb_reg, MASK_PIN);
                end
                OFS_PLAIN_OUT: begin
                    plain_out_reg <= merge(plain_out_reg, w_data_reg, w_strb_reg, MASK_PIN);
                end
                OFS_PLAIN_OE: begin
                    plain_oe_reg <= merge(plain_oe_reg, w_data_reg, w_strb_reg, MASK_PIN);
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    logic [31:0] rd_word;
    always_comb begin
        unique case (s_axi_araddr_i)
            OFS_ALT_TWO:   rd_word = alt_two_reg;
            OFS_ALT_THREE: rd_word = alt_three_reg;
            OFS_ALT_FOUR:  rd_word = alt_four_reg;
            OFS_DRIVER:    rd_word = driver_reg;
            OFS_PULLUP:    rd_word = pullup_reg;
            OFS_PLAIN_OUT: rd_word = plain_out_reg;
            OFS_PLAIN_OE:  rd_word = plain_oe_reg;
            default:       rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h00000000;
            s_axi_rresp_o   <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= rd_word;
            s_axi_rresp_o   <= known(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_o) begin
            if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end else begin
            s_axi_arready_o <= !s_axi_arready_o;
        end
    end

    // ****************************************************************
    // Function multiplexer
    // ****************************************************************
    // Overlapping selects are not arbitrated; software keeps them exclusive.
    logic [PIN_COUNT-1:0] func_en;
    logic [PIN_COUNT-1:0] func_val;
    logic [PIN_COUNT-1:0] func_oe;
    always_comb begin
        func_en  = alt_two_reg[PIN_COUNT-1:0] | alt_three_reg[PIN_COUNT-1:0] | alt_four_reg[PIN_COUNT-1:0];
        func_val = '0;
        func_oe  = '0;
        func_val[BIT_TX]   = serial4_transmit_line_i;
        func_oe[BIT_TX]    = alt_two_reg[BIT_TX];
        func_val[BIT_CLK]  = serial4_clock_out_i;
        func_oe[BIT_CLK]   = alt_two_reg[BIT_CLK] & serial4_clock_oe_i;
        func_val[BIT_TMR4] = timer4_output_i;
        func_oe[BIT_TMR4]  = alt_three_reg[BIT_TMR4];
        func_val[BIT_TMR5] = timer5_output_i;
        func_oe[BIT_TMR5]  = alt_three_reg[BIT_TMR5];
    end

    phf_pad_mux u_pad_mux (
        .clk_sys_i    (clk_sys_i),
        .rst_i        (rst_i),
        .func_en_i    (func_en),
        .func_val_i   (func_val),
        .func_oe_i    (func_oe),
        .plain_val_i  (plain_out_reg[PIN_COUNT-1:0]),
        .plain_oe_i   (plain_oe_reg[PIN_COUNT-1:0]),
        .open_drain_i (driver_reg[PIN_COUNT-1:0]),
        .pad_out_o    (pad_out_o),
        .pad_oe_o     (pad_oe_o)
    );

    // Serial inputs to peripherals idle high and counter inputs idle low when not routed, so a deselected pin looks quiet.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pad_pullup_o                 <= '0;
            serial4_receive_line_o       <= 1'b1;
            serial4_clock_line_o         <= 1'b1;
            serial4_clear_to_send_line_o <= 1'b1;
            pulse_counter3_input0_o      <= 1'b0;
            pulse_counter3_input1_o      <= 1'b0;
            port_in_o                    <= '0;
        end else begin
            pad_pullup_o                 <= pullup_reg[PIN_COUNT-1:0];
            serial4_receive_line_o       <= alt_two_reg[BIT_RX] ? pad_in_i[BIT_RX] : 1'b1;
            serial4_clock_line_o         <= alt_two_reg[BIT_CLK] ? pad_in_i[BIT_CLK] : 1'b1;
            serial4_clear_to_send_line_o <= alt_four_reg[BIT_CTS] ? pad_in_i[BIT_CTS] : 1'b1;
            pulse_counter3_input0_o      <= alt_two_reg[BIT_CNT0] & pad_in_i[BIT_CNT0];
            pulse_counter3_input1_o      <= alt_two_reg[BIT_CNT1] & pad_in_i[BIT_CNT1];
            port_in_o                    <= pad_in_i & ~func_en;
        end
    end
endmodule

/* File: testbench/phf_pin_model.sv */
// Board-side model of the seven port H pins.
// Assumes the bench chooses which pins the board drives and at what level.
`timescale 1ns/10ps
module phf_pin_model
    import phf_pkg::*;
(
    // Device side
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_i,
    input  wire logic [PIN_COUNT-1:0] pad_out_i,
    input  wire logic [PIN_COUNT-1:0] pad_oe_i,
    input  wire logic [PIN_COUNT-1:0] pad_pullup_i,
    // Board side
    input  wire logic [PIN_COUNT-1:0] ext_en_i,
    input  wire logic [PIN_COUNT-1:0] ext_val_i,
    output logic      [PIN_COUNT-1:0] pin_level_o
);
    logic [PIN_COUNT-1:0] float_reg;

    // A pin that nobody drives or pulls has no level, so it wanders every cycle.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) float_reg <= 7'h00;
        else float_reg <= ~float_reg;
    end

    // The device wins over the board; a pull-up only lifts a released pin.
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pad_oe_i[i]) pin_level_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) pin_level_o[i] = ext_val_i[i];
            else if (pad_pullup_i[i]) pin_level_o[i] = 1'b1;
            else pin_level_o[i] = float_reg[i];
        end
    end
endmodule

/* File: testbench/phf_port_h_sva.sv */
// Checker for the port H function block, bound to its top module.
// Assumes one clock and keeps a shadow of the low byte of each select, driver type and pull-up register.
`timescale 1ns/10ps
module phf_port_h_sva
    import phf_pkg::*;
(
    // Clock, reset and bus
    input wire logic                 clk_sys_i, rst_i, s_axi_awvalid_i, s_axi_awready_o,
    input wire logic                 s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_rvalid_o,
    input wire logic [7:0]           s_axi_awaddr_i,
    input wire logic [31:0]          s_axi_wdata_i, s_axi_rdata_o,
    input wire logic [3:0]           s_axi_wstrb_i,
    input wire logic [1:0]           s_axi_bresp_o,
    // Pads and peripherals
    input wire logic [PIN_COUNT-1:0] pad_in_i, pad_out_o, pad_pullup_o,
    input wire logic                 serial4_transmit_line_i, serial4_receive_line_o, serial4_clock_line_o,
    input wire logic                 serial4_clear_to_send_line_o, pulse_counter3_input0_o,
    input wire logic                 pulse_counter3_input1_o, timer4_output_i, timer5_output_i
);
    logic [7:0] addr_reg, data_reg, alt2_reg, alt3_reg, alt4_reg, od_reg, pu_reg;
    logic       strb_reg;
    logic [1:0] quiet_reg;
    logic       calm;

    // Outputs trail a register change, so pin checks wait until the setting has settled.
    assign calm = (quiet_reg == 2'h3);

    always_ff @(posedge clk_sys_i) begin
        if (s_axi_awvalid_i && s_axi_awready_o) addr_reg <= s_axi_awaddr_i;
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            data_reg <= s_axi_wdata_i[7:0];
            strb_reg <= s_axi_wstrb_i[0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {alt2_reg, alt3_reg, alt4_reg, od_reg, pu_reg} <= '0;
        end else if ($rose(s_axi_bvalid_o) && s_axi_bresp_o == RESP_OKAY && strb_reg) begin
            case (addr_reg)
                OFS_ALT_TWO:   alt2_reg <= data_reg & MASK_ALT_TWO[7:0];
                OFS_ALT_THREE: alt3_reg <= data_reg & MASK_ALT_THREE[7:0];
                OFS_ALT_FOUR:  alt4_reg <= data_reg & MASK_ALT_FOUR[7:0];
                OFS_DRIVER:    od_reg <= data_reg & MASK_PIN[7:0];
                OFS_PULLUP:    pu_reg <= data_reg & MASK_PIN[7:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || s_axi_bvalid_o) quiet_reg <= 2'h0;
        else if (!calm) quiet_reg <= quiet_reg + 2'h1;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_tx_route: assert property (calm && alt2_reg[0] && !od_reg[0] |-> pad_out_o[0] == $past(serial4_transmit_line_i))
        else $error("transmit line not on pin 0");
    a_rx_route: assert property (calm |-> serial4_receive_line_o == (alt2_reg[1] ? $past(pad_in_i[1]) : 1'b1))
        else $error("receive line wrong");
    a_clock_route: assert property (calm |-> serial4_clock_line_o == (alt2_reg[2] ? $past(pad_in_i[2]) : 1'b1))
        else $error("serial clock line wrong");
    a_count_route: assert property (calm |->
        {pulse_counter3_input1_o, pulse_counter3_input0_o} == ($past(pad_in_i[4:3]) & alt2_reg[4:3]))
        else $error("counter inputs wrong");
    a_timer_route: assert property (calm && alt3_reg[4:3] == 2'b11 && od_reg[4:3] == 2'b00 |->
        pad_out_o[4:3] == $past({timer5_output_i, timer4_output_i}))
        else $error("timer outputs not on pins 3 and 4");
    a_cts_route: assert property (calm |-> serial4_clear_to_send_line_o == (alt4_reg[2] ? $past(pad_in_i[2]) : 1'b1))
        else $error("clear to send line wrong");
    a_od_low: assert property (calm |-> (pad_out_o & od_reg[6:0]) == 7'h00)
        else $error("open drain pin driven high");
    a_pullup_map: assert property (calm |-> pad_pullup_o == pu_reg[6:0])
        else $error("pull-up outputs wrong");
    a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:7] == 25'h0)
        else $error("upper read bits not zero");

    c_serial_on: cover property (calm && alt2_reg == 8'h1f);
    c_od_on: cover property (calm && od_reg != 8'h00);
    c_refused: cover property ($rose(s_axi_bvalid_o) && s_axi_bresp_o == RESP_SLVERR);
endmodule

bind phf_port_h phf_port_h_sva phf_port_h_sva_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_bresp_o(s_axi_bresp_o),
    .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_pullup_o(pad_pullup_o),
    .serial4_transmit_line_i(serial4_transmit_line_i), .serial4_receive_line_o(serial4_receive_line_o),
    .serial4_clock_line_o(serial4_clock_line_o), .serial4_clear_to_send_line_o(serial4_clear_to_send_line_o),
    .pulse_counter3_input0_o(pulse_counter3_input0_o), .pulse_counter3_input1_o(pulse_counter3_input1_o),
    .timer4_output_i(timer4_output_i), .timer5_output_i(timer5_output_i)
);

/* File: testbench/test_phf_port_h.sv */
// Self-checking bench for the port H function block.
// Assumes the pin model on the pads and an AXI4-Lite master made of tasks.
`timescale 1ns/10ps
module test_phf_port_h
    import phf_pkg::*;
;
    localparam logic [7:0]  REG_OFS [5] = '{OFS_ALT_TWO, OFS_ALT_THREE, OFS_ALT_FOUR, OFS_DRIVER, OFS_PULLUP};
    localparam logic [31:0] REG_MASK [5] = '{MASK_ALT_TWO, MASK_ALT_THREE, MASK_ALT_FOUR, MASK_PIN, MASK_PIN};
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf, strb_sel = 4'hf;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rx, ck_line, cts, cnt0, cnt1;
    logic        tx = 1'b0, ck_out = 1'b0, ck_oe = 1'b0, tmr4 = 1'b0, tmr5 = 1'b0;
    logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pad_pu, port_in, ext_en = 7'h00, ext_val = 7'h00;
    int n_fail = 0;
    int n_compared = 0;

    phf_port_h phf_port_h_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pad_in_i(pad_in),
        .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pullup_o(pad_pu), .serial4_transmit_line_i(tx),
        .serial4_receive_line_o(rx), .serial4_clock_out_i(ck_out), .serial4_clock_oe_i(ck_oe),
        .serial4_clock_line_o(ck_line), .serial4_clear_to_send_line_o(cts), .pulse_counter3_input0_o(cnt0),
        .pulse_counter3_input1_o(cnt1), .timer4_output_i(tmr4), .timer5_output_i(tmr5), .port_in_o(port_in)
    );

    phf_pin_model phf_pin_model_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_pullup_i(pad_pu),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_level_o(pad_in)
    );

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The slave answers in its own time; only the watchdog cuts a hung transfer short.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys_i);
        awaddr <= a; wdata <= d; wstrb <= strb_sel;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check_word(32'(bresp), 32'(r));
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic test_registers();
        logic [31:0] d;
        logic [1:0] r;
        foreach (REG_OFS[i]) begin
            axi_read(REG_OFS[i], d, r);
            check_word(d, RESET_VALUE);
            axi_write(REG_OFS[i], 32'hffff_ffff, RESP_OKAY);
            axi_read(REG_OFS[i], d, r);
            check_word(d, REG_MASK[i]);
            axi_write(REG_OFS[i], 32'h0, RESP_OKAY);
        end
        axi_write(8'h18, 32'hffff_ffff, RESP_SLVERR);
        axi_read(8'h18, d, r);
        check_word({d[31:2], r}, {30'h0, RESP_SLVERR});
    endtask

    task automatic test_serial();
        logic [6:0] pat [2] = '{7'h5a, 7'h25};
        axi_write(OFS_ALT_TWO, 32'h1f, RESP_OKAY);
        ext_en <= 7'h7e;
        foreach (pat[i]) begin
            ext_val <= pat[i];
            tx <= pat[i][0];
            settle();
            check_word(32'(pad_out[0]), 32'(pat[i][0]));
            check_word(32'({ck_line, rx}), 32'(pat[i][2:1]));
            check_word(32'({cnt1, cnt0}), 32'(pat[i][4:3]));
            check_word(32'(port_in), 32'({pat[i][6:5], 5'h00}));
        end
        ck_out <= 1'b1;
        ck_oe <= 1'b1;
        settle();
        check_word(32'({pad_oe[2], pad_out[2]}), 32'h3);
        ck_oe <= 1'b0;
        axi_write(OFS_ALT_TWO, 32'h0, RESP_OKAY);
        settle();
        check_word(32'({ck_line, rx, cnt1, cnt0}), 32'hc);
    endtask

    task automatic test_timer_cts();
        logic [1:0] v [2] = '{2'b01, 2'b10};
        axi_write(OFS_ALT_THREE, 32'h18, RESP_OKAY);
        axi_write(OFS_ALT_FOUR, 32'h04, RESP_OKAY);
        ext_en <= 7'h04;
        foreach (v[i]) begin
            tmr4 <= v[i][0];
            tmr5 <= v[i][1];
            ext_val <= {4'h0, v[i][0], 2'b00};
            settle();
            check_word(32'(pad_out[4:3]), 32'(v[i]));
            check_word(32'(cts), 32'(v[i][0]));
        end
        axi_write(OFS_ALT_THREE, 32'h0, RESP_OKAY);
        axi_write(OFS_ALT_FOUR, 32'h0, RESP_OKAY);
        settle();
        check_word(32'(cts), 32'h1);
    endtask

    task automatic test_drivers();
        logic [31:0] d;
        logic [1:0] r;
        ext_en <= 7'h00;
        axi_write(OFS_PLAIN_OUT, 32'h55, RESP_OKAY);
        axi_write(OFS_PLAIN_OE, 32'h7f, RESP_OKAY);
        axi_write(OFS_DRIVER, 32'h0f, RESP_OKAY);
        axi_write(OFS_PULLUP, 32'h2a, RESP_OKAY);
        strb_sel = 4'he;
        axi_write(OFS_PULLUP, 32'h7f, RESP_OKAY);
        strb_sel = 4'hf;
        settle();
        check_word(32'(pad_out), 32'h50);
        check_word(32'(pad_oe), 32'h7a);
        check_word(32'(pad_pu), 32'h2a);
        axi_read(OFS_PULLUP, d, r);
        check_word(d, 32'h2a);
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // The whole sequence takes well under a thousand cycles; this cuts a hang short.
    initial begin
        #100us;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        test_registers();
        test_serial();
        test_timer_cts();
        test_drivers();
        wrap_up();
    end
endmodule
